/* mct_cmd_word.sv */
// One 32-bit command word built from two 16-bit halves, with 0-to-1 detection.
`timescale 1ns/1ps
`default_nettype none
module mct_cmd_word #(
    parameter logic [15:0] BASE = 16'h0180
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Register write port
    input  wire logic        wrEn,
    input  wire logic [15:0] wrAddr,
    input  wire logic [15:0] wrData,
    // Trigger
    output logic             fire
);
    logic [31:0] word_r;
    logic [31:0] word_nxt;
    logic        hiHit;
    logic        loHit;

    assign hiHit = wrEn && (wrAddr == BASE);
    assign loHit = wrEn && (wrAddr == BASE + 16'h0001);

    always_comb begin
        word_nxt = word_r;
        if (hiHit) begin
            word_nxt[31:16] = wrData;
        end
        if (loHit) begin
            word_nxt[15:0] = wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            word_r <= mct_pkg::CMD_RESET_VAL;
        end else begin
            word_r <= word_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            fire <= 1'b0;
        end else begin
            fire <= (hiHit || loHit) && (word_r == mct_pkg::CMD_RESET_VAL)
                    && (word_nxt == mct_pkg::CMD_ONE);
        end
    end
endmodule : mct_cmd_word
`default_nettype wire

/* mct_host_model.sv */
// Serial host model that writes the command register pairs.
`timescale 1ns/1ps
`default_nettype none
module mct_host_model (
    // Clock
    input  wire logic        clk,
    // Register write port
    output logic             regWrEn,
    output logic [15:0]      regAddr,
    output logic [15:0]      regWrData
);
    initial begin
        regWrEn = 1'b0;
        regAddr = 16'h0000;
        regWrData = 16'h0000;
    end
    // Released bus shows inverted values so stale data never looks valid.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr
    // both halves written, stores only when asked, no monitor reads.
    task automatic cmd(input int k, input logic [31:0] v);
        wr(16'h0180 + 16'(2 * k), v[31:16]);
        wr(16'h0181 + 16'(2 * k), v[15:0]);
    endtask : cmd
endmodule : mct_host_model
`default_nettype wire

/* mct_maint_cmd.sv */
// Top module: maintenance command triggers and their effects on driver state.
`timescale 1ns/1ps
`default_nettype none
module mct_maint_cmd #(
    // Widths and run length.
    parameter int unsigned ALARM_W  = 16,
    parameter int unsigned POS_W    = 32,
    parameter int unsigned ENTRY_W  = 8,
    parameter int unsigned PARAM_W  = 32,
    parameter int unsigned RECALC_N = mct_pkg::RECALC_CYCLES
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,

    // Register write port from the serial front end
    input  wire logic                     regWrEn,
    input  wire logic [15:0]              regAddr,
    input  wire logic [15:0]              regWrData,

    // Alarm state
    input  wire logic [ALARM_W-1:0]       alarmSet,
    input  wire logic [ALARM_W-1:0]       alarmNoClear,
    input  wire logic                     absFaultSet,
    output logic      [ALARM_W-1:0]       alarmActive,
    output logic                          absFault,

    // History logs
    input  wire logic                     alarmLogPush,
    input  wire logic                     warnLogPush,
    input  wire logic                     linkLogPush,
    input  wire logic [ENTRY_W-1:0]       logEntry,
    output logic      [mct_pkg::HIST_DEPTH*ENTRY_W-1:0] alarmLog,
    output logic      [mct_pkg::HIST_DEPTH*ENTRY_W-1:0] warnLog,
    output logic      [mct_pkg::HIST_DEPTH*ENTRY_W-1:0] linkLog,

    // Position
    input  wire logic [POS_W-1:0]         posPreset,
    input  wire logic                     posStep,
    input  wire logic                     posDirNeg,
    output logic      [POS_W-1:0]         cmdPosition,

    // Motion and tool status (pins, synchronised here)
    input  wire logic                     motorMoving,
    input  wire logic                     toolABusy,
    input  wire logic                     toolBBusy,
    input  wire logic                     autoReturnEn,
    input  wire logic                     autoReturnCond,

    // Drive control during recalculation
    output logic                          recalcBusy,
    output logic                          motorEnergize,
    output logic                          brakeHold,
    output logic                          inputsAccepted,
    output logic                          autoReturnGo,

    // Parameter storage
    output logic [PARAM_W-1:0]            ramParams,
    output logic [PARAM_W-1:0]            nvParams,
    output logic [7:0]                    serialCfg,
    output logic [31:0]                   nvWriteCount,
    input  wire logic [PARAM_W-1:0]       defaultParams,
    input  wire logic [PARAM_W-1:0]       ramParamsWr,
    input  wire logic                     ramParamsWe,
    input  wire logic [7:0]               serialCfgWr,
    input  wire logic                     serialCfgWe
);
    // Width of one whole history log.
    localparam int unsigned LOG_W = mct_pkg::HIST_DEPTH * ENTRY_W;

    // One-hot sequencer states.
    typedef enum logic [1:0] {
        MCT_IDLE = 2'b01,
        MCT_RUN  = 2'b10
    } mct_state_t;

    // Command fire pulses, one per register pair.
    logic [mct_pkg::NUM_CMD-1:0] fire;

    // Pin levels after the second synchroniser stage.
    localparam int unsigned PIN_N = 5;
    logic [PIN_N-1:0]            pinRaw;
    logic [PIN_N-1:0]            pinSync;
    logic                        toolA;
    logic                        toolB;
    logic                        moving;
    logic                        arEn_s;
    logic                        arCond_s;

    // Recalculation sequencer and auto return guard.
    mct_state_t                  state_r;
    logic [15:0]                 cnt_r;
    logic                        recalcOk;
    logic                        arBlock_r;

    localparam logic [15:0] BASES [mct_pkg::NUM_CMD] = '{
        mct_pkg::ADDR_ALARM_CLR,
        mct_pkg::ADDR_ABS_CLR,
        mct_pkg::ADDR_ALM_HIST,
        mct_pkg::ADDR_WRN_HIST,
        mct_pkg::ADDR_LNK_HIST,
        mct_pkg::ADDR_PRELOAD,
        mct_pkg::ADDR_RECALC,
        mct_pkg::ADDR_DEFAULTS,
        mct_pkg::ADDR_BATCH_LOAD,
        mct_pkg::ADDR_BATCH_STORE
    };

    // One command word per register pair.
    genvar gi;
    generate
        for (gi = 0; gi < mct_pkg::NUM_CMD; gi++) begin : gCmd
            mct_cmd_word #(
                .BASE   (BASES[gi])
            ) uWord (
                .clk    (clk),
                .resetn (resetn),
                .wrEn   (regWrEn),
                .wrAddr (regAddr),
                .wrData (regWrData),
                .fire   (fire[gi])
            );
        end
    endgenerate

    // Pin levels pass two flip-flops before use.
    // Each pin gets its own pair so nothing but the second stage reads the first.
    assign pinRaw = {autoReturnCond, autoReturnEn, toolBBusy, toolABusy, motorMoving};

    generate
        for (gi = 0; gi < PIN_N; gi++) begin : gSync
            logic meta_r;
            logic sync_r;

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= pinRaw[gi];
                    sync_r <= meta_r;
                end
            end

            assign pinSync[gi] = sync_r;
        end
    endgenerate

    assign moving   = pinSync[0];
    assign toolA    = pinSync[1];
    assign toolB    = pinSync[2];
    assign arEn_s   = pinSync[3];
    assign arCond_s = pinSync[4];

    // Alarm clear keeps exempt alarms.
    // A new alarm in the clear cycle survives, so no event is lost.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            alarmActive <= '0;
        end else if (fire[mct_pkg::CMD_ALARM_CLR]) begin
            alarmActive <= (alarmActive & alarmNoClear) | alarmSet;
        end else begin
            alarmActive <= alarmActive | alarmSet;
        end
    end

    // Dedicated fault clear; a new fault wins over the clear.
    // Only this command may clear it; the general alarm clear leaves it alone.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            absFault <= 1'b0;
        end else if (absFaultSet) begin
            absFault <= 1'b1;
        end else if (fire[mct_pkg::CMD_ABS_CLR]) begin
            absFault <= 1'b0;
        end
    end

    // History log erase.
    // Each log shifts up and keeps its newest entry in the low bits.
    always_ff @(posedge clk) begin
        if (!resetn || fire[mct_pkg::CMD_ALM_HIST]) begin
            alarmLog <= '0;
        end else if (alarmLogPush) begin
            alarmLog <= {alarmLog[LOG_W-ENTRY_W-1:0], logEntry};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || fire[mct_pkg::CMD_WRN_HIST]) begin
            warnLog <= '0;
        end else if (warnLogPush) begin
            warnLog <= {warnLog[LOG_W-ENTRY_W-1:0], logEntry};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || fire[mct_pkg::CMD_LNK_HIST]) begin
            linkLog <= '0;
        end else if (linkLogPush) begin
            linkLog <= {linkLog[LOG_W-ENTRY_W-1:0], logEntry};
        end
    end

    // Position preload.
    // Steps are ignored during a run because inputs are not accepted then.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmdPosition <= '0;
        end else if (fire[mct_pkg::CMD_PRELOAD]) begin
            cmdPosition <= posPreset;
        end else if (posStep && state_r == MCT_IDLE) begin
            cmdPosition <= posDirNeg ? cmdPosition - 1'b1 : cmdPosition + 1'b1;
        end
    end

    // All five start conditions together.
    // Synchronised levels only, so a glitch on a pin cannot start a run.
    assign recalcOk = (alarmActive == '0) && !absFault && !moving && !toolA && !toolB;

    // Recalculation sequencer; a refused trigger is simply dropped.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= MCT_IDLE;
        end else begin
            unique case (state_r)
                MCT_IDLE: begin
                    if (fire[mct_pkg::CMD_RECALC] && recalcOk) begin
                        state_r <= MCT_RUN;
                    end
                end
                MCT_RUN: begin
                    if (cnt_r == 16'h0000) begin
                        state_r <= MCT_IDLE;
                    end
                end
                default: begin
                    state_r <= MCT_IDLE;
                end
            endcase
        end
    end

    // Run length counter, preloaded while idle and counted down to zero.
    // The counter is 16 bits wide, which limits the run length parameter.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_r <= 16'h0000;
        end else if (state_r == MCT_IDLE) begin
            cnt_r <= RECALC_N[15:0] - 16'h0001;
        end else if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
        end
    end

    // Drive held safe while busy.
    // Other outputs are undefined during a run; these are pinned to safe levels.
    assign recalcBusy     = (state_r == MCT_RUN);
    assign motorEnergize  = !recalcBusy;
    assign brakeHold      = recalcBusy;
    assign inputsAccepted = !recalcBusy;

    // Block automatic return after recalculation until its condition drops.
    // Waiting for the condition to fall means a return never follows a run by itself.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            arBlock_r <= 1'b0;
        end else if (recalcBusy) begin
            arBlock_r <= 1'b1;
        end else if (!arCond_s) begin
            arBlock_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            autoReturnGo <= 1'b0;
        end else begin
            autoReturnGo <= arEn_s && arCond_s && !arBlock_r && !recalcBusy;
        end
    end

    // Defaults into storage; defaults win over a store in the same cycle.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            nvParams <= '0;
        end else if (fire[mct_pkg::CMD_DEFAULTS]) begin
            nvParams <= defaultParams;
        end else if (fire[mct_pkg::CMD_BATCH_STORE]) begin
            nvParams <= ramParams;
        end
    end

    // Storage into RAM; a load overrides a direct RAM write.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ramParams <= '0;
        end else if (fire[mct_pkg::CMD_BATCH_LOAD]) begin
            ramParams <= nvParams;
        end else if (ramParamsWe) begin
            ramParams <= ramParamsWr;
        end
    end

    // Serial settings are written only by their own port.
    // The defaults command has no path to these bits, so they survive it.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            serialCfg <= 8'h00;
        end else if (serialCfgWe) begin
            serialCfg <= serialCfgWr;
        end
    end

    // Wear counter lets software see how many stores have been spent.
    // Defaults rewrite storage as well, so they are counted too.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            nvWriteCount <= 32'h0000_0000;
        end else if (fire[mct_pkg::CMD_BATCH_STORE] || fire[mct_pkg::CMD_DEFAULTS]) begin
            nvWriteCount <= nvWriteCount + 32'h0000_0001;
        end
    end
endmodule : mct_maint_cmd
`default_nettype wire

/* mct_maint_cmd_chk.sv */
// Checker for the maintenance command block ports.
`timescale 1ns/1ps
`default_nettype none
module mct_maint_cmd_chk #(
    parameter int unsigned ALARM_W  = 16,
    parameter int unsigned POS_W    = 32,
    parameter int unsigned RECALC_N = 8
) (
    // Ports watched
    input wire logic               clk,
    input wire logic               resetn,
    input wire logic               regWrEn,
    input wire logic [15:0]        regAddr,
    input wire logic [15:0]        regWrData,
    input wire logic [ALARM_W-1:0] alarmActive,
    input wire logic [ALARM_W-1:0] alarmNoClear,
    input wire logic               absFault,
    input wire logic [POS_W-1:0]   posPreset,
    input wire logic [POS_W-1:0]   cmdPosition,
    input wire logic               recalcBusy,
    input wire logic               motorEnergize,
    input wire logic               brakeHold,
    input wire logic               inputsAccepted,
    input wire logic               autoReturnGo,
    input wire logic [7:0]         serialCfg,
    input wire logic               serialCfgWe,
    input wire logic [31:0]        nvWriteCount
);
    logic [15:0] pHi_r;
    logic [15:0] pLo_r;
    logic [15:0] busyCnt_r;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pHi_r <= 16'h0000;
            pLo_r <= 16'h0000;
        end else if (regWrEn && regAddr == 16'h018A) begin
            pHi_r <= regWrData;
        end else if (regWrEn && regAddr == 16'h018B) begin
            pLo_r <= regWrData;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn || !recalcBusy) begin
            busyCnt_r <= 16'h0000;
        end else begin
            busyCnt_r <= busyCnt_r + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_preload_fire: assert property (regWrEn && regAddr == 16'h018B && regWrData == 16'h0001
        && pHi_r == 16'h0000 && pLo_r != 16'h0001 |-> ##2 cmdPosition == $past(posPreset, 2))
        else $error("preload did not load the preset");
    a_alarm_keep: assert property ((($past(alarmActive) & $past(alarmNoClear)) & ~alarmActive) == '0)
        else $error("kept alarm was cleared");
    a_recalc_gate: assert property ($rose(recalcBusy) |-> alarmActive == '0 && !absFault)
        else $error("recalc started with an alarm");
    a_busy_drive: assert property (recalcBusy |-> !motorEnergize && brakeHold && !inputsAccepted)
        else $error("drive state wrong during recalc");
    a_idle_drive: assert property (!recalcBusy |-> motorEnergize && !brakeHold && inputsAccepted)
        else $error("drive state wrong after recalc");
    a_busy_len: assert property ($fell(recalcBusy) |-> busyCnt_r == 16'(RECALC_N))
        else $error("recalc length wrong");
    a_no_autoret: assert property ($fell(recalcBusy) |-> !autoReturnGo [*2])
        else $error("auto return right after recalc");
    a_serial_keep: assert property (!$past(serialCfgWe) |-> $stable(serialCfg))
        else $error("serial settings changed");
    a_nv_step: assert property ($changed(nvWriteCount) |-> nvWriteCount == $past(nvWriteCount) + 1)
        else $error("store count jumped");
endmodule : mct_maint_cmd_chk
bind mct_maint_cmd mct_maint_cmd_chk #(.ALARM_W(ALARM_W), .POS_W(POS_W), .RECALC_N(RECALC_N)) u_chk (
    .clk, .resetn, .regWrEn, .regAddr, .regWrData, .alarmActive, .alarmNoClear, .absFault,
    .posPreset, .cmdPosition, .recalcBusy, .motorEnergize, .brakeHold, .inputsAccepted,
    .autoReturnGo, .serialCfg, .serialCfgWe, .nvWriteCount);
`default_nettype wire

/* mct_pkg.sv */
// Package with register addresses and timing constants for the maintenance command block.
package mct_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned NUM_CMD = 10;
    // Upper half of each command pair; the lower half sits at the next address.
    localparam logic [15:0] ADDR_ALARM_CLR   = 16'h0180;
    localparam logic [15:0] ADDR_ABS_CLR     = 16'h0182;
    localparam logic [15:0] ADDR_ALM_HIST    = 16'h0184;
    localparam logic [15:0] ADDR_WRN_HIST    = 16'h0186;
    localparam logic [15:0] ADDR_LNK_HIST    = 16'h0188;
    localparam logic [15:0] ADDR_PRELOAD     = 16'h018A;
    localparam logic [15:0] ADDR_RECALC      = 16'h018C;
    localparam logic [15:0] ADDR_DEFAULTS    = 16'h018E;
    localparam logic [15:0] ADDR_BATCH_LOAD  = 16'h0190;
    localparam logic [15:0] ADDR_BATCH_STORE = 16'h0192;
    localparam logic [15:0] ADDR_FIRST       = ADDR_ALARM_CLR;
    localparam logic [15:0] ADDR_LAST        = 16'h0193;
    // Command indices inside the trigger vector.
    localparam int unsigned CMD_ALARM_CLR   = 0;
    localparam int unsigned CMD_ABS_CLR     = 1;
    localparam int unsigned CMD_ALM_HIST    = 2;
    localparam int unsigned CMD_WRN_HIST    = 3;
    localparam int unsigned CMD_LNK_HIST    = 4;
    localparam int unsigned CMD_PRELOAD     = 5;
    localparam int unsigned CMD_RECALC      = 6;
    localparam int unsigned CMD_DEFAULTS    = 7;
    localparam int unsigned CMD_BATCH_LOAD  = 8;
    localparam int unsigned CMD_BATCH_STORE = 9;
    localparam logic [31:0] CMD_RESET_VAL = 32'h0000_0000;
    localparam logic [31:0] CMD_ONE       = 32'h0000_0001;
    // Duration of the setup recalculation in microseconds and cycles at 100 MHz.
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned RECALC_US     = 10;
    localparam int unsigned RECALC_CYCLES = RECALC_US * CLK_MHZ;
    localparam int unsigned RECALC_CNT_W  = 16;
    // Number of history entries in each log.
    localparam int unsigned HIST_DEPTH = 10;
endpackage : mct_pkg

/* mct_tb.sv */
// Self-checking testbench for the maintenance command block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, resetn = 1'b0, regWrEn;
    logic [15:0] regAddr, regWrData, aSet = '0, noClr = '0, alarmActive;
    logic absSet = 0, aPush = 0, wPush = 0, lPush = 0, posStep = 0, absFault;
    logic moving = 0, tA = 0, tB = 0, arEn = 0, arCond = 0, recalcBusy, motorEnergize;
    logic brakeHold, inputsAccepted, autoReturnGo, ramWe = 0, cfgWe = 0;
    logic [79:0] alarmLog, warnLog, linkLog;
    logic [31:0] preset = '0, cmdPosition, ramParams, nvParams, nvWriteCount;
    logic [31:0] ramWr = '0, defP = 32'h0000_1111;
    logic [7:0] serialCfg, cfgWr = '0;
    int failures = 0, testsRun = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    mct_host_model u_mct_host_model (.clk(clk), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData));
    mct_maint_cmd #(.RECALC_N(8)) u_mct_maint_cmd (.clk(clk), .resetn(resetn),
        .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .alarmSet(aSet),
        .alarmNoClear(noClr), .absFaultSet(absSet), .alarmActive(alarmActive),
        .absFault(absFault), .alarmLogPush(aPush), .warnLogPush(wPush), .linkLogPush(lPush),
        .logEntry(8'h3C), .alarmLog(alarmLog), .warnLog(warnLog), .linkLog(linkLog),
        .posPreset(preset), .posStep(posStep), .posDirNeg(1'b0), .cmdPosition(cmdPosition),
        .motorMoving(moving), .toolABusy(tA), .toolBBusy(tB), .autoReturnEn(arEn),
        .autoReturnCond(arCond), .recalcBusy(recalcBusy), .motorEnergize(motorEnergize),
        .brakeHold(brakeHold), .inputsAccepted(inputsAccepted), .autoReturnGo(autoReturnGo),
        .ramParams(ramParams), .nvParams(nvParams), .serialCfg(serialCfg),
        .nvWriteCount(nvWriteCount), .defaultParams(defP), .ramParamsWr(ramWr),
        .ramParamsWe(ramWe), .serialCfgWr(cfgWr), .serialCfgWe(cfgWe));
    task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
        testsRun++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic cmd(input int k, input logic [31:0] v);
        u_mct_host_model.cmd(k, v);
        tick(3);
    endtask : cmd
    task automatic t_preload();
        @(posedge clk) preset <= 32'h1234_5678;
        cmd(5, 1);
        chk("pos", 80'h1234_5678, cmdPosition);
        @(posedge clk) preset <= 32'h0BAD_0001;
        cmd(5, 1);
        u_mct_host_model.wr(16'h0194, 16'h0001);
        chk("pos", 80'h1234_5678, cmdPosition);
        cmd(5, 0);
        cmd(5, 32'h0001_0001);
        chk("pos", 80'h1234_5678, cmdPosition);
        cmd(5, 0);
        cmd(5, 1);
        chk("pos", 80'h0BAD_0001, cmdPosition);
        $display("test preload done");
    endtask : t_preload
    task automatic t_alarm();
        @(posedge clk) begin aSet <= 16'h00FF; absSet <= 1; noClr <= 16'h0003; end
        @(posedge clk) begin aSet <= '0; absSet <= 0; end
        cmd(0, 1);
        chk("alarm", 80'h0003, alarmActive);
        chk("abs", 80'h1, absFault);
        cmd(1, 1);
        chk("abs", 80'h0, absFault);
        $display("test alarm done");
    endtask : t_alarm
    task automatic t_hist();
        @(posedge clk) begin aPush <= 1; wPush <= 1; lPush <= 1; end
        @(posedge clk) begin aPush <= 0; wPush <= 0; lPush <= 0; end
        cmd(2, 1);
        chk("alog", 80'h0, alarmLog);
        chk("wlog", 80'h3C, warnLog);
        cmd(3, 1);
        chk("wlog", 80'h0, warnLog);
        chk("llog", 80'h3C, linkLog);
        cmd(4, 1);
        chk("llog", 80'h0, linkLog);
        $display("test history done");
    endtask : t_hist
    task automatic t_recalc();
        cmd(6, 1);
        chk("busy", 80'h0, recalcBusy);
        @(posedge clk) begin noClr <= '0; arEn <= 1; arCond <= 1; end
        cmd(0, 0);
        cmd(0, 1);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) begin moving <= (i == 0); tA <= (i == 1); tB <= (i == 2); end
            tick(4);
            cmd(6, 0);
            cmd(6, 1);
            chk("busy", 80'h0, recalcBusy);
        end
        @(posedge clk) tB <= 0;
        tick(4);
        cmd(6, 0);
        u_mct_host_model.cmd(6, 1);
        for (int i = 0; i < 10 && recalcBusy !== 1'b1; i++) tick(1);
        chk("busy", 80'h1, recalcBusy);
        chk("drive", 80'h2, {inputsAccepted, brakeHold, motorEnergize});
        @(posedge clk) posStep <= 1;
        @(posedge clk) posStep <= 0;
        for (int i = 0; i < 20 && recalcBusy !== 1'b0; i++) tick(1);
        chk("pos", 80'h0BAD_0001, cmdPosition);
        chk("inacc", 80'h1, inputsAccepted);
        tick(2);
        chk("autoret", 80'h0, autoReturnGo);
        @(posedge clk) arCond <= 0;
        tick(4);
        @(posedge clk) arCond <= 1;
        tick(5);
        chk("autoret", 80'h1, autoReturnGo);
        $display("test recalc done");
    endtask : t_recalc
    task automatic t_params();
        @(posedge clk) begin cfgWr <= 8'h5A; cfgWe <= 1; ramWr <= 32'hA5A5_0F0F; ramWe <= 1; end
        @(posedge clk) begin cfgWe <= 0; ramWe <= 0; end
        cmd(9, 1);
        chk("nv", 80'hA5A5_0F0F, nvParams);
        chk("nvcnt", 80'h1, nvWriteCount);
        @(posedge clk) begin ramWr <= 32'h0000_7777; ramWe <= 1; end
        @(posedge clk) ramWe <= 0;
        cmd(8, 1);
        chk("ram", 80'hA5A5_0F0F, ramParams);
        cmd(7, 1);
        chk("nv", 80'h0000_1111, nvParams);
        chk("cfg", 80'h5A, serialCfg);
        cmd(8, 0);
        cmd(8, 1);
        chk("ram", 80'h0000_1111, ramParams);
        $display("test params done");
    endtask : t_params
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        tick(20);
        @(posedge clk) resetn <= 1'b1;
        t_preload();
        t_alarm();
        t_hist();
        t_recalc();
        t_params();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
